// file: inc/lsu_map.svh
`ifndef LSU_MAP_SVH
`define LSU_MAP_SVH

// Data unit widths.
`define LSU_WORD_BITS 32
`define LSU_HALF_BITS 16
`define LSU_DWORD_BITS 64
`define LSU_BYTE_BITS 8
// Most significant bit carries a Boolean.
`define LSU_BOOL_POS 31
// Largest multiple-word transfer.
`define LSU_MAX_WORDS 192
// Width of the instruction constant address.
`define LSU_CONST_ADDR_BITS 8
// Buffer depth for returned load words.
`define LSU_FIFO_DEPTH 8
// Register file geometry.
`define LSU_REG_COUNT 256
`define LSU_REG_BITS 8

`endif

// file: inc/lsu_pkg.sv
package lsu_pkg;
  typedef enum logic [2:0] {
    OP_LOAD = 3'h0,
    OP_STORE = 3'h1,
    OP_INTERLOCKED_LOAD = 3'h2,
    OP_INTERLOCKED_STORE = 3'h3,
    OP_MULTI_WORD_LOAD = 3'h4,
    OP_MULTI_WORD_STORE = 3'h5
  } op_t;

  typedef enum logic [1:0] {
    SIZE_WORD = 2'h0,
    SIZE_HALF = 2'h1,
    SIZE_BYTE = 2'h2
  } size_t_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ISSUE = 2'b01,
    ST_WAIT = 2'b10
  } state_t;
endpackage : lsu_pkg

// file: verilog/lsu_fifo.sv
`include "lsu_map.svh"

module lsu_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = `LSU_FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Fill side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : lsu_fifo

// file: verilog/lsu_lane.sv
`include "lsu_map.svh"

// Lane steering for loads and stores under either byte order.
module lsu_lane (
  // Access shape.
  input wire logic [1:0] addr_low,
  input wire lsu_pkg::size_t_t size,
  input wire logic big_endian,
  input wire logic byte_access_en,
  // Data.
  input wire logic [`LSU_WORD_BITS-1:0] load_word,
  input wire logic [`LSU_WORD_BITS-1:0] store_reg,
  output logic [`LSU_WORD_BITS-1:0] load_result,
  output logic [`LSU_WORD_BITS-1:0] store_word
);
  import lsu_pkg::*;

  logic [1:0] byte_lane;
  logic half_lane;

  always_comb begin
    byte_lane = big_endian ? ~addr_low : addr_low;
    half_lane = big_endian ? ~addr_low[1] : addr_low[1];
  end

  always_comb begin
    load_result = load_word;
    if (byte_access_en && size == SIZE_BYTE) begin
      load_result = {24'h00_0000, load_word[{byte_lane, 3'b000} +: `LSU_BYTE_BITS]};
    end else if (byte_access_en && size == SIZE_HALF) begin
      load_result = {16'h0000, load_word[{half_lane, 4'b0000} +: `LSU_HALF_BITS]};
    end
  end

  always_comb begin
    store_word = store_reg;
    if (byte_access_en && size == SIZE_BYTE) begin
      store_word = {4{store_reg[`LSU_BYTE_BITS-1:0]}};
    end else if (byte_access_en && size == SIZE_HALF) begin
      store_word = {2{store_reg[`LSU_HALF_BITS-1:0]}};
    end
  end
endmodule : lsu_lane

// file: verilog/load_store_data_unit.sv
`include "lsu_map.svh"

module load_store_data_unit #(
  parameter int MAX_WORDS = `LSU_MAX_WORDS,
  parameter int FIFO_DEPTH = `LSU_FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Configuration.
  input wire logic big_endian,
  input wire logic byte_access_en,
  // Command from the pipeline.
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire lsu_pkg::op_t cmd_op,
  input wire lsu_pkg::size_t_t cmd_size,
  input wire logic cmd_use_const,
  input wire logic [`LSU_WORD_BITS-1:0] cmd_addr_reg,
  input wire logic [`LSU_CONST_ADDR_BITS-1:0] cmd_addr_const,
  input wire logic [`LSU_REG_BITS-1:0] cmd_reg,
  input wire logic [7:0] cmd_count,
  input wire logic [`LSU_WORD_BITS-1:0] cmd_store_data,
  // Interrupt of a multiple transfer.
  input wire logic suspend,
  input wire logic resume,
  output logic suspended,
  // Register file read port for multiple-word stores.
  output logic [`LSU_REG_BITS-1:0] rf_rd_addr,
  input wire logic [`LSU_WORD_BITS-1:0] rf_rd_data,
  // Register file write port for loads.
  output logic rf_we,
  output logic [`LSU_REG_BITS-1:0] rf_wr_addr,
  output logic [`LSU_WORD_BITS-1:0] rf_wr_data,
  // Hazard check from the pipeline.
  input wire logic [`LSU_REG_BITS-1:0] use_reg,
  input wire logic use_valid,
  output logic stall,
  // External bus.
  output logic bus_req,
  output logic bus_write,
  output logic bus_lock,
  output logic [`LSU_WORD_BITS-1:0] bus_addr,
  output logic [`LSU_WORD_BITS-1:0] bus_wdata,
  input wire logic bus_ack,
  input wire logic [`LSU_WORD_BITS-1:0] bus_rdata,
  // Status.
  output logic busy,
  output logic bool_busy
);
  import lsu_pkg::*;

  localparam int FW = `LSU_WORD_BITS + `LSU_REG_BITS;

  state_t state;
  op_t op;
  size_t_t size;
  logic [`LSU_WORD_BITS-1:0] addr;
  logic [`LSU_REG_BITS-1:0] reg_idx;
  logic [7:0] remaining;
  logic [`LSU_WORD_BITS-1:0] single_store;
  logic is_load;
  logic is_multi;
  logic is_lock;
  logic cmd_take;
  logic [`LSU_REG_COUNT-1:0] pending;
  logic [`LSU_WORD_BITS-1:0] load_result;
  logic [`LSU_WORD_BITS-1:0] store_word;
  logic [`LSU_WORD_BITS-1:0] store_src;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [FW-1:0] fifo_in_data;
  logic fifo_out_valid;
  logic [FW-1:0] fifo_out_data;
  logic [`LSU_REG_COUNT-1:0] set_mask;
  logic [`LSU_REG_COUNT-1:0] clr_mask;
  logic [7:0] first_count;
  logic word_done;
  logic last_word;
  logic stop_now;
  logic start_word;

  // ==========================================
  // Command decode.
  assign is_load = (op == OP_LOAD) || (op == OP_INTERLOCKED_LOAD) ||
                   (op == OP_MULTI_WORD_LOAD);
  assign is_multi = (op == OP_MULTI_WORD_LOAD) || (op == OP_MULTI_WORD_STORE);
  assign is_lock = (op == OP_INTERLOCKED_LOAD) || (op == OP_INTERLOCKED_STORE);
  assign cmd_take = cmd_valid && cmd_ready;

  // ==========================================
  // Word handshake.
  // A word ends only when the far side acknowledges a standing request.
  assign word_done = bus_req && bus_ack;
  assign last_word = (remaining == 8'h01);
  assign stop_now = suspend && is_multi;

  // A new request may start once no earlier one stands. Suspension is taken only
  // between words, so a request already on the bus is never withdrawn.
  always_comb begin
    start_word = 1'b0;
    if (state == ST_ISSUE && (!bus_req || bus_ack)) begin
      start_word = !(word_done && last_word) && !stop_now && (!is_load || fifo_in_ready);
    end
  end

  // ==========================================
  // Transfer length.
  // clamp multiple count
  always_comb begin
    first_count = 8'h01;
    if (cmd_op == OP_MULTI_WORD_LOAD || cmd_op == OP_MULTI_WORD_STORE) begin
      if (cmd_count == 8'h00) begin
        first_count = 8'h01;
      end else if (cmd_count > 8'(MAX_WORDS)) begin
        first_count = 8'(MAX_WORDS);
      end else begin
        first_count = cmd_count;
      end
    end
  end

  // ==========================================
  // Transfer sequencing.
  // one word each
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      op <= OP_LOAD;
      size <= SIZE_WORD;
      addr <= 32'h0000_0000;
      reg_idx <= 8'h00;
      remaining <= 8'h00;
      single_store <= 32'h0000_0000;
      suspended <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (cmd_take) begin
            op <= cmd_op;
            size <= cmd_size;
            addr <= cmd_use_const ? {24'h00_0000, cmd_addr_const} : cmd_addr_reg;
            reg_idx <= cmd_reg;
            remaining <= first_count;
            single_store <= cmd_store_data;
            state <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          if (word_done) begin
            if (last_word) begin
              state <= ST_IDLE;
              remaining <= 8'h00;
            end else begin
              // Word addresses step by four bytes.
              addr <= addr + 32'h0000_0004;
              reg_idx <= reg_idx + 8'h01;
              remaining <= remaining - 8'h01;
              if (stop_now) begin
                suspended <= 1'b1;
                state <= ST_WAIT;
              end
            end
          end else if (!bus_req && stop_now) begin
            suspended <= 1'b1;
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (resume) begin
            suspended <= 1'b0;
            state <= ST_ISSUE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // Command acceptance.
  // Ready mirrors the idle state from a flip-flop, so the pipeline sees no logic path.
  // accept next only once back in the idle state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ready <= 1'b1;
    end else if (state == ST_IDLE) begin
      cmd_ready <= !cmd_take;
    end else begin
      cmd_ready <= (state == ST_ISSUE) && word_done && last_word;
    end
  end

  // ==========================================
  // External bus.
  // bus request only mid-transfer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus_req <= 1'b0;
      bus_write <= 1'b0;
      bus_lock <= 1'b0;
      bus_addr <= 32'h0000_0000;
      bus_wdata <= 32'h0000_0000;
    end else begin
      // A standing request holds until its acknowledge.
      bus_req <= (bus_req && !bus_ack) || start_word;
      bus_write <= (state == ST_ISSUE) && !is_load;
      bus_lock <= (state == ST_ISSUE) && is_lock;
      bus_addr <= (word_done && !last_word) ? addr + 32'h0000_0004 : addr;
      // Store data is captured once per word and then held with the request.
      if (start_word) begin
        bus_wdata <= store_word;
      end
    end
  end

  // ==========================================
  // Store data source.
  assign store_src = is_multi ? rf_rd_data : single_store;

  // The read port points at the register of the next word to start, one step
  // ahead of the bus, so back-to-back stores never resend the previous word.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rf_rd_addr <= 8'h00;
    end else if (cmd_take) begin
      rf_rd_addr <= cmd_reg;
    end else if (start_word) begin
      rf_rd_addr <= rf_rd_addr + 8'h01;
    end
  end

  // ==========================================
  // Lane steering.
  lsu_lane u_lane (
    .addr_low(bus_addr[1:0]),
    .size(size),
    .big_endian(big_endian),
    .byte_access_en(byte_access_en),
    .load_word(bus_rdata),
    .store_reg(store_src),
    .load_result(load_result),
    .store_word(store_word)
  );

  // ==========================================
  // Load return.
  // Returned words queue here so a busy write port cannot lose them.
  assign fifo_in_valid = word_done && is_load;
  assign fifo_in_data = {reg_idx, load_result};

  lsu_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(1'b1),
    .out_data(fifo_out_data)
  );

  // ==========================================
  // Write-back.
  // write back loaded data
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rf_we <= 1'b0;
      rf_wr_addr <= 8'h00;
      rf_wr_data <= 32'h0000_0000;
    end else begin
      rf_we <= fifo_out_valid;
      rf_wr_addr <= fifo_out_data[FW-1 -: `LSU_REG_BITS];
      rf_wr_data <= fifo_out_data[`LSU_WORD_BITS-1:0];
    end
  end

  // ==========================================
  // Load scoreboard.
  // Scoreboard of registers still waiting for load data; a set wins over a clear.
  always_comb begin
    set_mask = '0;
    clr_mask = '0;
    if (cmd_take && (cmd_op == OP_LOAD || cmd_op == OP_INTERLOCKED_LOAD)) begin
      set_mask[cmd_reg] = 1'b1;
    end
    if (cmd_take && cmd_op == OP_MULTI_WORD_LOAD) begin
      for (int i = 0; i < `LSU_REG_COUNT; i++) begin
        if (8'(i - int'(cmd_reg)) < first_count) begin
          set_mask[i] = 1'b1;
        end
      end
    end
    if (rf_we) begin
      clr_mask[rf_wr_addr] = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pending <= '0;
    end else begin
      pending <= (pending & ~clr_mask) | set_mask;
    end
  end

  // ==========================================
  // Hazard stall.
  // stall pending reader
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stall <= 1'b0;
    end else begin
      stall <= use_valid && (pending[use_reg] || set_mask[use_reg]);
    end
  end

  // ==========================================
  // Status.
  // fixed word width
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      bool_busy <= 1'b0;
    end else begin
      busy <= (state != ST_IDLE) || cmd_take || fifo_out_valid;
      bool_busy <= (state != ST_IDLE);
    end
  end
endmodule : load_store_data_unit

// file: verif/lsu_mem_model.sv
module lsu_mem_model (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Answer latency in cycles.
  input wire logic [1:0] delay,
  // Bus.
  input wire logic bus_req,
  input wire logic [31:0] bus_addr,
  output logic bus_ack,
  output logic [31:0] bus_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt;
  logic [31:0] last;
  assign bus_ack = bus_req && (cnt == delay);
  // Outside an answer the data lines show garbage, never the last word.
  assign bus_rdata = bus_ack ? (bus_addr ^ 32'h5A5A_0F0F) : ~last;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) cnt <= 2'h0;
    else if (bus_ack || !bus_req) cnt <= 2'h0;
    else cnt <= cnt + 2'h1;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) last <= 32'h0000_0000;
    else if (bus_ack) last <= bus_rdata;
  end
endmodule : lsu_mem_model

// file: verif/load_store_data_unit_properties.sv
module load_store_data_unit_properties #(
  parameter int MAX_WORDS = 192
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Command.
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire lsu_pkg::op_t cmd_op,
  input wire logic cmd_use_const,
  input wire logic [7:0] cmd_addr_const,
  // Write-back and bus.
  input wire logic rf_we,
  input wire logic [7:0] rf_wr_addr,
  input wire logic bus_req,
  input wire logic bus_write,
  input wire logic bus_lock,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_ack,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  import lsu_pkg::*;
  logic take;
  assign take = cmd_valid && cmd_ready;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_no_idle_req: assert property (!busy |-> !bus_req)
    else $error("bus request while idle");
  a_take_to_req: assert property (take |-> ##2 bus_req)
    else $error("bus request late after command");
  a_req_holds: assert property (bus_req && !bus_ack |=> bus_req && $stable(bus_addr))
    else $error("bus request dropped or moved before ack");
  a_busy_refuses: assert property (bus_req |-> !cmd_ready)
    else $error("command accepted during transfer");
  a_wdata_holds: assert property (bus_req && !bus_ack |=> $stable(bus_wdata))
    else $error("store data moved before ack");
  a_multi_addr_step: assert property (bus_req && bus_ack ##1 bus_req
    |-> bus_addr == $past(bus_addr) + 32'h0000_0004)
    else $error("multiple transfer address step wrong");
  a_wb_reg_step: assert property (rf_we ##1 rf_we |-> rf_wr_addr == $past(rf_wr_addr) + 8'h01)
    else $error("multiple load register step wrong");
  a_ack_to_wb: assert property (bus_req && bus_ack && !bus_write |-> ##2 rf_we)
    else $error("loaded word not written back");
  a_const_addr: assert property (take && cmd_use_const && cmd_op inside {OP_LOAD, OP_STORE}
    |-> ##2 bus_addr == {24'h00_0000, $past(cmd_addr_const, 2)})
    else $error("constant address altered");
  a_lock_set: assert property (take && cmd_op inside {OP_INTERLOCKED_LOAD, OP_INTERLOCKED_STORE}
    |-> ##2 bus_lock)
    else $error("interlocked access without lock");
endmodule : load_store_data_unit_properties

bind load_store_data_unit load_store_data_unit_properties #(.MAX_WORDS(MAX_WORDS)) u_props (
  .clock, .rst_n, .cmd_valid, .cmd_ready, .cmd_op, .cmd_use_const, .cmd_addr_const, .rf_we,
  .rf_wr_addr, .bus_req, .bus_write, .bus_lock, .bus_addr, .bus_wdata, .bus_ack, .busy);

// file: verif/load_store_data_unit_bench.sv
module load_store_data_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import lsu_pkg::*;
  // Small ceiling so the clamp shows in a short run.
  localparam int MW = 8;
  logic clock = 0, rst_n = 0, big_endian = 0, byte_access_en = 0, cmd_valid = 0;
  logic cmd_use_const = 0, suspend = 0, resume = 0, use_valid = 0;
  op_t cmd_op = OP_LOAD;
  size_t_t cmd_size = SIZE_WORD;
  logic [31:0] cmd_addr_reg = 0, cmd_store_data = 0, bus_addr, bus_wdata, bus_rdata;
  logic [31:0] rf_wr_data, rf_rd_data;
  logic [7:0] cmd_addr_const = 0, cmd_reg = 0, cmd_count = 0, use_reg = 0, rf_rd_addr, rf_wr_addr;
  logic [1:0] delay = 0;
  logic cmd_ready, suspended, rf_we, stall, bus_req, bus_write, bus_lock, bus_ack, busy, bool_busy;
  int bad_count = 0, n_checks = 0;
  logic [39:0] exp_wb[$];
  logic [64:0] exp_bus[$];

  always #2.5 clock = ~clock;
  assign rf_rd_data = {rf_rd_addr, 8'h3C, ~rf_rd_addr, 8'hA5};
  load_store_data_unit #(.MAX_WORDS(MW)) dut (.*);
  lsu_mem_model mem (.*);

  // ==========================================
  // Checking
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out;
    if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  always @(posedge clock) begin
    if (rst_n && rf_we) begin
      if (exp_wb.size() == 0) chk({24'h0, rf_wr_addr}, 32'hFFFF_FFFF);
      else begin
        chk({24'h0, rf_wr_addr}, {24'h0, exp_wb[0][39:32]});
        chk(rf_wr_data, exp_wb[0][31:0]);
        void'(exp_wb.pop_front());
      end
    end
    if (rst_n && bus_req && bus_ack) begin
      if (exp_bus.size() == 0) chk(bus_addr, ~bus_addr);
      else begin
        chk({31'h0, bus_write}, {31'h0, exp_bus[0][64]});
        chk(bus_addr, exp_bus[0][63:32]);
        if (exp_bus[0][64]) chk(bus_wdata, exp_bus[0][31:0]);
        void'(exp_bus.pop_front());
      end
    end
  end

  // ==========================================
  // Reference model and stimulus
  function automatic logic [31:0] lane(input logic [31:0] w, input logic [1:0] a, size_t_t sz);
    int s;
    if (!byte_access_en || sz == SIZE_WORD) return w;
    s = big_endian ? 3 - a : a;
    if (sz == SIZE_BYTE) return {24'h0, w[8*s+:8]};
    return {16'h0, w[16*(s/2)+:16]};
  endfunction : lane

  task automatic wait_idle;
    for (int i = 0; i < 600; i++) begin
      @(posedge clock);
      if (cmd_ready && !busy && exp_wb.size() == 0 && exp_bus.size() == 0) return;
    end
    bad_count++;
    close_out();
  endtask : wait_idle

  task automatic issue(op_t op, size_t_t sz, logic uc, logic [31:0] a, logic [7:0] r,
                       logic [7:0] n, logic [31:0] d, logic w);
    int k;
    logic [31:0] x, v;
    logic [7:0] g;
    @(posedge clock);
    k = (op >= OP_MULTI_WORD_LOAD) ? ((n == 0) ? 1 : (n > MW) ? MW : n) : 1;
    if (byte_access_en) v = (sz == SIZE_BYTE) ? {4{d[7:0]}} : (sz == SIZE_HALF) ? {2{d[15:0]}} : d;
    else v = d;
    for (int i = 0; i < k; i++) begin
      x = (uc ? {24'h0, a[7:0]} : a) + 32'(4 * i);
      g = r + 8'(i);
      if (op inside {OP_LOAD, OP_INTERLOCKED_LOAD, OP_MULTI_WORD_LOAD}) begin
        exp_bus.push_back({1'b0, x, 32'h0});
        exp_wb.push_back({g, lane(x ^ 32'h5A5A_0F0F, x[1:0], sz)});
      end else if (op == OP_MULTI_WORD_STORE) exp_bus.push_back({1'b1, x, g, 8'h3C, ~g, 8'hA5});
      else exp_bus.push_back({1'b1, x, v});
    end
    cmd_valid <= 1;
    cmd_op <= op;
    cmd_size <= sz;
    cmd_use_const <= uc;
    cmd_addr_reg <= a;
    cmd_addr_const <= a[7:0];
    cmd_reg <= r;
    cmd_count <= n;
    cmd_store_data <= d;
    @(posedge clock);
    cmd_valid <= 0;
    repeat (2) @(posedge clock);
    if (w) wait_idle();
  endtask : issue

  initial begin
    void'($urandom(45));
    repeat (12) @(posedge clock);
    rst_n <= 1;
    // Every single op, size, byte order and lane-select setting.
    for (int i = 0; i < 48; i++) begin
      @(posedge clock);
      big_endian <= 1'(i / 12 % 2);
      byte_access_en <= 1'(i / 24);
      delay <= 2'($urandom_range(3));
      issue(op_t'(i % 4), size_t_t'(i / 4 % 3), i[3], $urandom, 8'($urandom), 0,
            $urandom, 1);
    end
    issue(OP_MULTI_WORD_LOAD, SIZE_WORD, 0, $urandom, 8'h10, 0, 0, 1);
    issue(OP_MULTI_WORD_LOAD, SIZE_WORD, 0, $urandom, 8'hFC, 12, 0, 1);
    issue(OP_MULTI_WORD_STORE, SIZE_WORD, 0, $urandom, 8'h40, 5, 0, 1);
    delay <= 2;
    issue(OP_MULTI_WORD_LOAD, SIZE_WORD, 0, $urandom, 8'h20, 6, 0, 0);
    suspend <= 1;
    repeat (6) @(posedge clock);
    #1 chk({31'h0, suspended}, 32'h1);
    chk({31'h0, bus_req}, 32'h0);
    chk({31'h0, bool_busy}, 32'h1);
    chk({31'h0, busy}, 32'h1);
    @(posedge clock);
    suspend <= 0;
    resume <= 1;
    @(posedge clock);
    resume <= 0;
    wait_idle();
    delay <= 3;
    issue(OP_LOAD, SIZE_WORD, 0, $urandom, 8'h33, 0, 0, 0);
    use_reg <= 8'h33;
    use_valid <= 1;
    @(posedge clock);
    #1 chk({31'h0, stall}, 32'h1);
    @(posedge clock);
    use_valid <= 0;
    wait_idle();
    chk({31'h0, bool_busy}, 32'h0);
    chk({31'h0, cmd_ready}, 32'h1);
    close_out();
  end
endmodule : load_store_data_unit_bench
